// File: core/rtc_core.sv
`timescale 1ns/1ps
// Operation
// - 16-bit counter advances per prescaled tick, compared to period and compare values.
// - compare flag and event on the first tick after count equals compare.
// - wrap flag and event on first tick after count equals period; count returns to zero.
// - 15-bit prescaler divides the timebase, ratio chosen by the prescale field.
// - source select picks crystal, external clock, internal oscillator or oscillator/32.
// - periodic tick timer runs whether or not the counter is enabled.
// - periodic irq every 4..32768 slow periods; level events for 64..8192.
// - counter enable bit one starts the counter, zero stops it.
// - periodic enable bit one starts the periodic timer, zero stops it.
// - counter tick and periodic timer share one prescaler counter.
// - prescaler runs while either enable is set and stops when both clear.
// - periodic output toggles each half period; each rising edge sets its flag.
// - correction enable applies the signed ppm error from the calibration register.
// - error magnitude cycles skipped or inserted evenly per million cycles, by sign.
// - correction steps of one ppm, at most 127 either way.
// - correction affects both the count value and periodic intervals.
// - clearing correction enable finishes the running correction interval first.
// - wrap and compare events last one slow period; periodic events are levels.
// - irq stays active while flag and its enable are both set.
// - busy flags for compare, period, count, control and periodic control writes.
// - counter runs in idle, in standby only with standby run; periodic always runs.
module rtc_core #(
   parameter int CORR_CYCLES = rtc_pkg::CORR_INTERVAL
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [6:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic crystal_in_pin,
   input wire logic ext_clk_in,
   input wire logic internal_low_power_osc,
   input wire logic sleep_idle,
   input wire logic sleep_standby,
   output logic rtc_irq,
   output logic pit_irq,
   output logic wrap_event,
   output logic compare_event,
   output logic [7:0] pit_events
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   // bus request decode
   logic acc_req;
   logic wr_req;
   logic [4:0] idx;
   logic [15:0] wd;
   assign acc_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_req = acc_req & wb_we_i;
   assign idx = wb_adr_i[6:2];
   assign wd = wb_dat_i[15:0];

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d, input logic [1:0] sel);
      merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction : merge

   // software-visible registers
   logic [7:0] main_control_reg_ff;
   logic [15:0] period_value_ff;
   logic [15:0] compare_value_ff;
   logic [7:0] periodic_control_reg_ff;
   logic [7:0] crystal_calibration_reg_ff;
   logic [1:0] source_select_field_ff;
   logic [1:0] irq_enable_reg_ff;
   logic periodic_irq_enable_ff;
   logic [1:0] flags_ff;
   logic pit_flag_ff;
   logic [15:0] count_value_ff;
   logic [15:0] cnt_wr_ff;
   logic [3:0] busy_ff;
   logic periodic_control_sync_busy_ff;
   // values in effect on the slow timebase side
   logic [7:0] ctrl_act_ff;
   logic [15:0] per_act_ff;
   logic [15:0] cmp_act_ff;
   logic [7:0] pit_act_ff;

   logic wr_ctrl, wr_cnt, wr_per, wr_cmp, wr_pit;
   assign wr_ctrl = wr_req & (idx == rtc_pkg::IDX_MAIN_CTRL) & wb_sel_i[0];
   assign wr_cnt = wr_req & (idx == rtc_pkg::IDX_COUNT) & (|wb_sel_i[1:0]);
   assign wr_per = wr_req & (idx == rtc_pkg::IDX_PERIOD) & (|wb_sel_i[1:0]);
   assign wr_cmp = wr_req & (idx == rtc_pkg::IDX_COMPARE) & (|wb_sel_i[1:0]);
   assign wr_pit = wr_req & (idx == rtc_pkg::IDX_PIT_CTRL) & wb_sel_i[0];

   // slow timebase: rising edges of the selected source become one-cycle ticks
   logic [2:0] src_prev_ff;
   logic [4:0] osc_div_ff;
   logic xtal_rise, ext_rise, osc_rise, slow_tick;
   assign xtal_rise = crystal_in_pin & ~src_prev_ff[0];
   assign ext_rise = ext_clk_in & ~src_prev_ff[1];
   assign osc_rise = internal_low_power_osc & ~src_prev_ff[2];

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         src_prev_ff <= 3'h0;
         osc_div_ff <= 5'h00;
      end else begin
         src_prev_ff <= {internal_low_power_osc, ext_clk_in, crystal_in_pin};
         if (osc_rise) begin
            osc_div_ff <= osc_div_ff + 5'h01;
         end
      end
   end

   always_comb begin
      unique case (rtc_pkg::rtc_src_t'(source_select_field_ff))
         rtc_pkg::RTC_SRC_OSC: slow_tick = osc_rise;
         rtc_pkg::RTC_SRC_OSC_DIV32: slow_tick = osc_rise & (osc_div_ff == rtc_pkg::OSC_DIV_LAST);
         rtc_pkg::RTC_SRC_XTAL: slow_tick = xtal_rise;
         rtc_pkg::RTC_SRC_EXT: slow_tick = ext_rise;
      endcase
   end

   // register writes; pending values move to the slow side on the next slow tick
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         main_control_reg_ff <= rtc_pkg::CTRL_RST;
         period_value_ff <= rtc_pkg::PERIOD_RST;
         compare_value_ff <= rtc_pkg::COMPARE_RST;
         periodic_control_reg_ff <= rtc_pkg::CTRL_RST;
         crystal_calibration_reg_ff <= rtc_pkg::CRYSTAL_CALIBRATION_REG_RST;
         source_select_field_ff <= 2'h0;
         irq_enable_reg_ff <= 2'h0;
         periodic_irq_enable_ff <= 1'b0;
         cnt_wr_ff <= 16'h0000;
      end else if (wr_req & (|wb_sel_i[1:0])) begin
         // byte-wide registers live in lane 0 only
         unique case (idx)
            rtc_pkg::IDX_MAIN_CTRL: main_control_reg_ff <= wb_sel_i[0] ? wd[7:0] : main_control_reg_ff;
            rtc_pkg::IDX_CRYSTAL_CALIBRATION_REG: crystal_calibration_reg_ff <= wb_sel_i[0] ? wd[7:0] : crystal_calibration_reg_ff;
            rtc_pkg::IDX_SRC_SEL: source_select_field_ff <= wb_sel_i[0] ? wd[1:0] : source_select_field_ff;
            rtc_pkg::IDX_IRQ_EN: irq_enable_reg_ff <= wb_sel_i[0] ? wd[1:0] : irq_enable_reg_ff;
            rtc_pkg::IDX_PIT_CTRL: periodic_control_reg_ff <= wb_sel_i[0] ? wd[7:0] : periodic_control_reg_ff;
            rtc_pkg::IDX_PIT_IRQ_EN: periodic_irq_enable_ff <= wb_sel_i[0] ? wd[0] : periodic_irq_enable_ff;
            rtc_pkg::IDX_COUNT: cnt_wr_ff <= merge(count_value_ff, wd, wb_sel_i[1:0]);
            rtc_pkg::IDX_PERIOD: period_value_ff <= merge(period_value_ff, wd, wb_sel_i[1:0]);
            rtc_pkg::IDX_COMPARE: compare_value_ff <= merge(compare_value_ff, wd, wb_sel_i[1:0]);
            default: ;
         endcase
      end
   end

   // busy: a new write sets, applying at a slow tick clears; set wins
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         busy_ff <= 4'h0;
         periodic_control_sync_busy_ff <= 1'b0;
         ctrl_act_ff <= rtc_pkg::CTRL_RST;
         per_act_ff <= rtc_pkg::PERIOD_RST;
         cmp_act_ff <= rtc_pkg::COMPARE_RST;
         pit_act_ff <= rtc_pkg::CTRL_RST;
      end else begin
         busy_ff[rtc_pkg::BSY_CTRL] <= wr_ctrl | (busy_ff[rtc_pkg::BSY_CTRL] & ~slow_tick);
         busy_ff[rtc_pkg::BSY_CNT] <= wr_cnt | (busy_ff[rtc_pkg::BSY_CNT] & ~slow_tick);
         busy_ff[rtc_pkg::BSY_PER] <= wr_per | (busy_ff[rtc_pkg::BSY_PER] & ~slow_tick);
         busy_ff[rtc_pkg::BSY_CMP] <= wr_cmp | (busy_ff[rtc_pkg::BSY_CMP] & ~slow_tick);
         periodic_control_sync_busy_ff <= wr_pit | (periodic_control_sync_busy_ff & ~slow_tick);
         ctrl_act_ff <= (slow_tick & busy_ff[rtc_pkg::BSY_CTRL]) ? main_control_reg_ff : ctrl_act_ff;
         per_act_ff <= (slow_tick & busy_ff[rtc_pkg::BSY_PER]) ? period_value_ff : per_act_ff;
         cmp_act_ff <= (slow_tick & busy_ff[rtc_pkg::BSY_CMP]) ? compare_value_ff : cmp_act_ff;
         pit_act_ff <= (slow_tick & periodic_control_sync_busy_ff) ? periodic_control_reg_ff : pit_act_ff;
      end
   end

   // shared prescaler with crystal correction
   logic cnt_en, pit_en, presc_run, rtc_run;
   logic [14:0] presc_ff;
   logic corr_active_ff, corr_neg_ff, extra_step_ff;
   logic [6:0] corr_err_ff;
   logic [19:0] interval_ff, accum_ff, accum_sum;
   logic corr_evt, interval_end, presc_step;
   assign cnt_en = ctrl_act_ff[rtc_pkg::CTL_CNT_EN];
   assign pit_en = pit_act_ff[rtc_pkg::PIT_EN_BIT];
   assign presc_run = cnt_en | pit_en;
   assign rtc_run = cnt_en & (~sleep_standby | ctrl_act_ff[rtc_pkg::CTL_STBY_RUN]);
   assign accum_sum = accum_ff + {13'h0000, corr_err_ff};
   assign corr_evt = slow_tick & presc_run & corr_active_ff & (accum_sum >= 20'(CORR_CYCLES));
   assign interval_end = slow_tick & presc_run & (interval_ff == 20'(CORR_CYCLES - 1));
   // inserted cycles hold the prescaler, skipped ones add a step one bus cycle later
   assign presc_step = (slow_tick & presc_run & ~(corr_evt & corr_neg_ff)) | extra_step_ff;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         corr_active_ff <= 1'b0;
         corr_neg_ff <= 1'b0;
         corr_err_ff <= 7'h00;
         interval_ff <= 20'h00000;
         accum_ff <= 20'h00000;
         extra_step_ff <= 1'b0;
      end else begin
         extra_step_ff <= corr_evt & ~corr_neg_ff;
         if (interval_end | (~corr_active_ff & slow_tick)) begin
            // a new interval only starts at a boundary, so a disable finishes the current one
            corr_active_ff <= ctrl_act_ff[rtc_pkg::CTL_CORR_EN];
            corr_neg_ff <= crystal_calibration_reg_ff[rtc_pkg::CAL_SIGN];
            corr_err_ff <= crystal_calibration_reg_ff[6:0];
            interval_ff <= 20'h00000;
            accum_ff <= 20'h00000;
         end else if (slow_tick & presc_run) begin
            interval_ff <= interval_ff + 20'h00001;
            accum_ff <= corr_evt ? accum_sum - 20'(CORR_CYCLES) : accum_sum;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         presc_ff <= 15'h0000;
      end else if (presc_step) begin
         presc_ff <= presc_ff + 15'h0001;
      end
   end

   // main counter
   logic [3:0] presc_sel;
   logic [14:0] presc_mask;
   logic cnt_tick, at_per, at_cmp, cnt_load;
   assign presc_sel = ctrl_act_ff[rtc_pkg::CTL_PRESC_LSB +: 4];
   assign presc_mask = 15'((16'h0001 << presc_sel) - 16'h0001);
   assign cnt_tick = presc_step & rtc_run & ((presc_ff & presc_mask) == presc_mask);
   assign at_per = count_value_ff == per_act_ff;
   assign at_cmp = count_value_ff == cmp_act_ff;
   assign cnt_load = slow_tick & busy_ff[rtc_pkg::BSY_CNT];

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         count_value_ff <= 16'h0000;
      end else if (cnt_load) begin
         count_value_ff <= cnt_wr_ff;
      end else if (cnt_tick) begin
         count_value_ff <= at_per ? 16'h0000 : count_value_ff + 16'h0001;
      end
   end

   // periodic tick timer: square wave from one prescaler bit
   logic [3:0] pit_per;
   logic pit_out_ff, pit_prev_ff;
   assign pit_per = pit_act_ff[rtc_pkg::PIT_PER_LSB +: 4];

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pit_out_ff <= 1'b0;
         pit_prev_ff <= 1'b0;
         pit_events <= 8'h00;
      end else begin
         pit_out_ff <= pit_en & (pit_per != 4'h0) & (pit_per <= rtc_pkg::PIT_PER_MAX) & presc_ff[pit_per];
         pit_prev_ff <= pit_out_ff;
         pit_events <= pit_en ? presc_ff[rtc_pkg::PIT_EV_LSB +: 8] : 8'h00;
      end
   end

   // flags: hardware set wins over a write-one clear
   logic [1:0] flag_clr;
   logic pit_clr, pit_set;
   assign flag_clr = (wr_req & wb_sel_i[0] & (idx == rtc_pkg::IDX_FLAGS)) ? wd[1:0] : 2'h0;
   assign pit_clr = wr_req & wb_sel_i[0] & (idx == rtc_pkg::IDX_PIT_FLAGS) & wd[0];
   assign pit_set = pit_out_ff & ~pit_prev_ff;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         flags_ff <= 2'h0;
         pit_flag_ff <= 1'b0;
         rtc_irq <= 1'b0;
         pit_irq <= 1'b0;
         wrap_event <= 1'b0;
         compare_event <= 1'b0;
      end else begin
         flags_ff[rtc_pkg::FLG_WRAP] <= (cnt_tick & at_per) | (flags_ff[rtc_pkg::FLG_WRAP] & ~flag_clr[0]);
         flags_ff[rtc_pkg::FLG_CMP] <= (cnt_tick & at_cmp) | (flags_ff[rtc_pkg::FLG_CMP] & ~flag_clr[1]);
         pit_flag_ff <= pit_set | (pit_flag_ff & ~pit_clr);
         rtc_irq <= |(flags_ff & irq_enable_reg_ff);
         pit_irq <= pit_flag_ff & periodic_irq_enable_ff;
         // wrap and compare events held until the next slow tick
         wrap_event <= (cnt_tick & at_per) | (wrap_event & ~slow_tick);
         compare_event <= (cnt_tick & at_cmp) | (compare_event & ~slow_tick);
      end
   end

   // bus slave: one wait state, unmapped reads return zero
   logic [15:0] rd;
   always_comb begin
      unique case (idx)
         rtc_pkg::IDX_MAIN_CTRL: rd = {8'h00, main_control_reg_ff};
         rtc_pkg::IDX_STATUS: rd = {12'h000, busy_ff};
         rtc_pkg::IDX_IRQ_EN: rd = {14'h0000, irq_enable_reg_ff};
         rtc_pkg::IDX_FLAGS: rd = {14'h0000, flags_ff};
         rtc_pkg::IDX_CRYSTAL_CALIBRATION_REG: rd = {8'h00, crystal_calibration_reg_ff};
         rtc_pkg::IDX_SRC_SEL: rd = {14'h0000, source_select_field_ff};
         rtc_pkg::IDX_COUNT: rd = count_value_ff;
         rtc_pkg::IDX_PERIOD: rd = period_value_ff;
         rtc_pkg::IDX_COMPARE: rd = compare_value_ff;
         rtc_pkg::IDX_PIT_CTRL: rd = {8'h00, periodic_control_reg_ff};
         rtc_pkg::IDX_PIT_STATUS: rd = {15'h0000, periodic_control_sync_busy_ff};
         rtc_pkg::IDX_PIT_IRQ_EN: rd = {15'h0000, periodic_irq_enable_ff};
         rtc_pkg::IDX_PIT_FLAGS: rd = {15'h0000, pit_flag_ff};
         default: rd = 16'h0000;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= acc_req;
         if (acc_req & ~wb_we_i) begin
            wb_dat_o <= {16'h0000, rd};
         end
      end
   end
   // checks
   property p_wrap_clears;
      cnt_tick && at_per && !cnt_load |=> count_value_ff == 16'h0000 && flags_ff[0];
   endproperty
   a_wrap_clears: assert property (p_wrap_clears) else $error("wrap did not clear count");
   property p_cmp_flag;
      cnt_tick && at_cmp |=> flags_ff[1] ##1 compare_event || $past(slow_tick);
   endproperty
   a_cmp_flag: assert property (p_cmp_flag) else $error("compare match lost");
   property p_count_up;
      cnt_tick && !at_per && !cnt_load |=> count_value_ff == $past(count_value_ff) + 16'h0001;
   endproperty
   a_count_up: assert property (p_count_up) else $error("count did not advance");
   property p_presc_stops;
      !presc_run && !extra_step_ff |=> $stable(presc_ff);
   endproperty
   a_presc_stops: assert property (p_presc_stops) else $error("prescaler ran while off");
   property p_irq_level;
      (|(flags_ff & irq_enable_reg_ff)) |=> rtc_irq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq not held");
   property p_irq_idle;
      !(|(flags_ff & irq_enable_reg_ff)) |=> !rtc_irq;
   endproperty
   a_irq_idle: assert property (p_irq_idle) else $error("irq without flag and enable");
   property p_busy_done;
      busy_ff[0] && slow_tick && !wr_ctrl |=> !busy_ff[0] && ctrl_act_ff == main_control_reg_ff;
   endproperty
   a_busy_done: assert property (p_busy_done) else $error("control write not applied");
   property p_pit_edge;
      $rose(pit_out_ff) |=> pit_flag_ff;
   endproperty
   a_pit_edge: assert property (p_pit_edge) else $error("periodic edge lost");
   property p_event_hold;
      wrap_event && !slow_tick |=> wrap_event;
   endproperty
   a_event_hold: assert property (p_event_hold) else $error("wrap event dropped early");
   property p_corr_finish;
      corr_active_ff && !interval_end |=> corr_active_ff;
   endproperty
   a_corr_finish: assert property (p_corr_finish) else $error("correction stopped mid interval");
endmodule : rtc_core

// File: inc/rtc_pkg.sv
package rtc_pkg;
   // register indexes; byte address is four times the index
   localparam logic [4:0] IDX_MAIN_CTRL = 5'h00;
   localparam logic [4:0] IDX_STATUS = 5'h01;
   localparam logic [4:0] IDX_IRQ_EN = 5'h02;
   localparam logic [4:0] IDX_FLAGS = 5'h03;
   localparam logic [4:0] IDX_CRYSTAL_CALIBRATION_REG = 5'h06;
   localparam logic [4:0] IDX_SRC_SEL = 5'h07;
   localparam logic [4:0] IDX_COUNT = 5'h08;
   localparam logic [4:0] IDX_PERIOD = 5'h0A;
   localparam logic [4:0] IDX_COMPARE = 5'h0C;
   localparam logic [4:0] IDX_PIT_CTRL = 5'h10;
   localparam logic [4:0] IDX_PIT_STATUS = 5'h11;
   localparam logic [4:0] IDX_PIT_IRQ_EN = 5'h12;
   localparam logic [4:0] IDX_PIT_FLAGS = 5'h13;
   // main control fields
   localparam int CTL_CNT_EN = 0;
   localparam int CTL_CORR_EN = 1;
   localparam int CTL_PRESC_LSB = 3;
   localparam int CTL_STBY_RUN = 7;
   // status busy bits
   localparam int BSY_CTRL = 0;
   localparam int BSY_CNT = 1;
   localparam int BSY_PER = 2;
   localparam int BSY_CMP = 3;
   // flag and irq enable bits, calibration sign bit and periodic control fields
   localparam int FLG_WRAP = 0;
   localparam int FLG_CMP = 1;
   localparam int CAL_SIGN = 7;
   localparam int PIT_EN_BIT = 0;
   localparam int PIT_PER_LSB = 3;
   localparam logic [3:0] PIT_PER_MAX = 4'hE;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [15:0] PERIOD_RST = 16'hFFFF;
   localparam logic [15:0] COMPARE_RST = 16'h0000;
   localparam logic [7:0] CRYSTAL_CALIBRATION_REG_RST = 8'h00;
   // timing
   localparam int CORR_INTERVAL = 1000000;
   localparam int PIT_EV_LSB = 5;
   localparam logic [4:0] OSC_DIV_LAST = 5'h1F;
   typedef enum logic [1:0] {
      RTC_SRC_OSC = 2'h0,
      RTC_SRC_OSC_DIV32 = 2'h1,
      RTC_SRC_XTAL = 2'h2,
      RTC_SRC_EXT = 2'h3
   } rtc_src_t;
endpackage : rtc_pkg

// File: verification/test_rtc_core.sv
`timescale 1ns/1ps
module test_rtc_core;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [6:0] wb_adr_i = 7'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic crystal_in_pin = 1'b0;
   logic internal_low_power_osc = 1'b0;
   logic sleep_standby = 1'b0;
   logic rtc_irq;
   logic pit_irq;
   logic wrap_event;
   logic compare_event;
   logic [7:0] pit_events;
   logic [2:0] div_ff = 3'h0;
   logic [31:0] rd;
   logic [31:0] cnt_hold;
   int miscompares = 0;
   int samples_checked = 0;
   logic [4:0] ridx [6] = '{rtc_pkg::IDX_MAIN_CTRL, rtc_pkg::IDX_PERIOD, rtc_pkg::IDX_COMPARE,
                            rtc_pkg::IDX_CRYSTAL_CALIBRATION_REG, rtc_pkg::IDX_STATUS, 5'h1F};
   logic [31:0] rexp [6] = '{32'h0000_0000, 32'h0000_FFFF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                             32'h0000_0000};

   rtc_core #(.CORR_CYCLES(1000)) i_dut (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .crystal_in_pin(crystal_in_pin), .ext_clk_in(1'b0),
      .internal_low_power_osc(internal_low_power_osc), .sleep_idle(1'b0), .sleep_standby(sleep_standby),
      .rtc_irq(rtc_irq), .pit_irq(pit_irq), .wrap_event(wrap_event), .compare_event(compare_event),
      .pit_events(pit_events));

   always #20 clk_sys = ~clk_sys;

   // slow timebase of eight bus cycles, well above the four-to-one minimum
   always @(posedge clk_sys) begin
      div_ff <= div_ff + 3'h1;
      internal_low_power_osc <= div_ff[2];
      crystal_in_pin <= ~div_ff[2];
   end

   task summarize;
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : summarize

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task wb_acc(input logic we, input logic [4:0] idx, input logic [31:0] wdat, output logic [31:0] rdat);
      logic ok;
      int n;
      ok = 1'b0;
      rdat = 32'h0000_0000;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= 4'h3;
      wb_dat_i <= wdat;
      for (n = 0; n < 20 && ok !== 1'b1; n++) begin
         @(posedge clk_sys);
         if (wb_ack_o === 1'b1) begin
            ok = 1'b1;
            rdat = wb_dat_o;
         end
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_sys);
      if (ok !== 1'b1) begin
         miscompares++;
         $display("wrong value at %0t: no bus acknowledge", $time);
         summarize();
      end
   endtask : wb_acc

   task wait_idle(input logic [4:0] idx);
      logic [31:0] st;
      int n;
      st = 32'hFFFF_FFFF;
      for (n = 0; n < 50 && st !== 32'h0000_0000; n++) begin
         wb_acc(1'b0, idx, 32'h0000_0000, st);
      end
      chk(st, 32'h0000_0000, "sync busy stuck");
   endtask : wait_idle

   task wait_sig(input int which);
      logic s;
      int n;
      s = 1'b0;
      for (n = 0; n < 1000 && s !== 1'b1; n++) begin
         @(posedge clk_sys);
         case (which)
            0: s = compare_event;
            1: s = wrap_event;
            2: s = pit_irq;
            default: s = pit_events[0];
         endcase
      end
      if (s !== 1'b1) begin
         miscompares++;
         $display("wrong value at %0t: output %0d never rose", $time, which);
         summarize();
      end
   endtask : wait_sig

   initial begin
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < 6; i++) begin
         wb_acc(1'b0, ridx[i], 32'h0000_0000, rd);
         chk(rd, rexp[i], "reset value");
      end
      wb_acc(1'b1, rtc_pkg::IDX_STATUS, 32'h0000_00FF, rd);
      wb_acc(1'b1, 5'h1F, 32'h0000_00FF, rd);
      wb_acc(1'b0, rtc_pkg::IDX_STATUS, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0000, "status is read only");
      wb_acc(1'b1, rtc_pkg::IDX_SRC_SEL, 32'h0000_0000, rd);
      wb_acc(1'b1, rtc_pkg::IDX_PERIOD, 32'h0000_0002, rd);
      wb_acc(1'b1, rtc_pkg::IDX_COMPARE, 32'h0000_0001, rd);
      wb_acc(1'b1, rtc_pkg::IDX_CRYSTAL_CALIBRATION_REG, 32'h0000_0085, rd);
      wb_acc(1'b0, rtc_pkg::IDX_CRYSTAL_CALIBRATION_REG, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0085, "calibration readback");
      wb_acc(1'b0, rtc_pkg::IDX_PERIOD, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0002, "period readback");
      wb_acc(1'b1, rtc_pkg::IDX_IRQ_EN, 32'h0000_0003, rd);
      wb_acc(1'b1, rtc_pkg::IDX_MAIN_CTRL, 32'h0000_0001, rd);
      wait_idle(rtc_pkg::IDX_STATUS);
      wait_sig(0);
      wb_acc(1'b0, rtc_pkg::IDX_COUNT, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0002, "count after compare match");
      wait_sig(1);
      wb_acc(1'b0, rtc_pkg::IDX_COUNT, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0000, "count after wrap");
      wb_acc(1'b0, rtc_pkg::IDX_FLAGS, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0003, "wrap and compare flags");
      chk({31'h0, rtc_irq}, 32'h0000_0001, "irq with flag and enable");
      wb_acc(1'b1, rtc_pkg::IDX_IRQ_EN, 32'h0000_0000, rd);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, rtc_irq}, 32'h0000_0000, "irq masked");
      wb_acc(1'b1, rtc_pkg::IDX_MAIN_CTRL, 32'h0000_0000, rd);
      wait_idle(rtc_pkg::IDX_STATUS);
      wb_acc(1'b1, rtc_pkg::IDX_FLAGS, 32'h0000_0003, rd);
      wb_acc(1'b0, rtc_pkg::IDX_FLAGS, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0000, "flags cleared");
      wb_acc(1'b0, rtc_pkg::IDX_COUNT, 32'h0000_0000, cnt_hold);
      wb_acc(1'b1, rtc_pkg::IDX_PIT_IRQ_EN, 32'h0000_0001, rd);
      wb_acc(1'b1, rtc_pkg::IDX_PIT_CTRL, 32'h0000_0009, rd);
      wait_idle(rtc_pkg::IDX_PIT_STATUS);
      wait_sig(2);
      wb_acc(1'b0, rtc_pkg::IDX_PIT_FLAGS, 32'h0000_0000, rd);
      chk(rd, 32'h0000_0001, "periodic flag");
      wait_sig(3);
      wb_acc(1'b0, rtc_pkg::IDX_COUNT, 32'h0000_0000, rd);
      chk(rd, cnt_hold, "count frozen while only periodic runs");
      wb_acc(1'b1, rtc_pkg::IDX_PIT_CTRL, 32'h0000_0000, rd);
      wait_idle(rtc_pkg::IDX_PIT_STATUS);
      wb_acc(1'b1, rtc_pkg::IDX_PIT_FLAGS, 32'h0000_0001, rd);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, pit_irq}, 32'h0000_0000, "periodic irq cleared");
      chk({24'h0, pit_events}, 32'h0000_0000, "periodic events off");
      wb_acc(1'b1, rtc_pkg::IDX_PERIOD, 32'h0000_FFFF, rd);
      wb_acc(1'b1, rtc_pkg::IDX_CRYSTAL_CALIBRATION_REG, 32'h0000_007F, rd);
      wb_acc(1'b1, rtc_pkg::IDX_MAIN_CTRL, 32'h0000_000B, rd);
      wait_idle(rtc_pkg::IDX_STATUS);
      repeat (40) @(posedge clk_sys);
      wb_acc(1'b0, rtc_pkg::IDX_COUNT, 32'h0000_0000, cnt_hold);
      repeat (8000) @(posedge clk_sys);
      wb_acc(1'b0, rtc_pkg::IDX_COUNT, 32'h0000_0000, rd);
      rd = rd - cnt_hold;
      // about 1000 slow periods plus 127 skipped cycles, halved by the prescaler
      chk({31'h0, rd >= 32'h0000_0231 && rd <= 32'h0000_0236}, 32'h0000_0001, "corrected count rate");
      sleep_standby <= 1'b1;
      @(posedge clk_sys);
      wb_acc(1'b0, rtc_pkg::IDX_COUNT, 32'h0000_0000, cnt_hold);
      repeat (80) @(posedge clk_sys);
      wb_acc(1'b0, rtc_pkg::IDX_COUNT, 32'h0000_0000, rd);
      chk(rd, cnt_hold, "count frozen in standby");
      sleep_standby <= 1'b0;
      summarize();
   end
endmodule : test_rtc_core
